// file: etr_pkg.sv
/*
  Shared constants for the elapsed-time recorder two-wire link: address
  fields, bus timing and alarm/event timing counts at a 10 MHz core clock.
  Assumes both ends compile this package first.
*/
package etr_pkg;
  // ***********************************************************
  // address fields
  // ***********************************************************
  localparam logic [3:0] CTRL_CODE   = 4'hD;
  localparam logic [2:0] SELECT_BITS = 3'h3;
  localparam int         CODE_MSB    = 7;
  localparam int         CODE_LSB    = 4;
  localparam int         SEL_MSB     = 3;
  localparam int         SEL_LSB     = 1;
  localparam int         DIR_BIT     = 0;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_HZ        = 10000000;
  localparam int SCL_KHZ       = 100;
  localparam int SCL_HALF_CYC  = CLK_HZ / (SCL_KHZ * 1000 * 2);
  localparam int LOCKOUT_MS    = 500;
  localparam int LOCKOUT_CYC   = LOCKOUT_MS * (CLK_HZ / 1000);
  localparam int STORE_MIN_MS  = 50;
  localparam int STORE_MAX_MS  = 100;
  localparam int STORE_CYC     = ((STORE_MIN_MS + STORE_MAX_MS) / 2) * (CLK_HZ / 1000);
  localparam real FLASH_LOW_MS  = 62.5;
  localparam real FLASH_HIGH_MS = 437.5;
  localparam int FLASH_LOW_CYC  = int'(FLASH_LOW_MS * (CLK_HZ / 1000));
  localparam int FLASH_HIGH_CYC = int'(FLASH_HIGH_MS * (CLK_HZ / 1000));
  localparam int TRIG_MS       = 500;
  localparam int TRIG_CYC      = TRIG_MS * (CLK_HZ / 1000);
  localparam int FLASH_COUNT   = 4;
endpackage

// file: etr_link_if.sv
/*
  Two-wire link between master and recorder slave; open-drain wires are
  resolved here from the enables. Assumes one master and one slave.
*/
`timescale 1ns/1ps
interface etr_link_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl;
  logic sda;
  // ***********************************************************
  // wired-and with pull-up
  // ***********************************************************
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport slave  (output sda_oe_s, input scl, input sda);
endinterface

// file: etr_slave.sv
/*
  Recorder slave end: two-wire slave, alarm flash timer, event store and
  lockout timers. Assumes bus levels synchronous to sys_clk.
*/
`timescale 1ns/1ps
module etr_slave
  import etr_pkg::*;
#(
  parameter int LOCKOUT_N = LOCKOUT_CYC,
  parameter int STORE_N   = STORE_CYC,
  parameter int FL_LOW_N  = FLASH_LOW_CYC,
  parameter int FL_HIGH_N = FLASH_HIGH_CYC,
  parameter int TRIG_N    = TRIG_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  etr_link_if.slave       link,
  input  wire logic [7:0] tx_data,
  output logic            tx_take,
  output logic [7:0]      rx_data_r,
  output logic            rx_valid_r,
  output logic            rd_mode_r,
  output logic            addressed_r,
  input  wire logic       event_end,
  input  wire logic       flash_mode,
  input  wire logic       alarm_in,
  output logic            alarm_oe_r,
  output logic            store_done_r,
  output logic            lockout_r
);
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_MACK} st_e;
  st_e        st_r;
  logic       scl_d_r, sda_d_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic       sda_oe_r;
  logic       start_c, stop_c, rise_c, fall_c;

  assign start_c = scl_d_r & link.scl & sda_d_r & ~link.sda;
  assign stop_c  = scl_d_r & link.scl & ~sda_d_r & link.sda;
  assign rise_c  = ~scl_d_r & link.scl;
  assign fall_c  = scl_d_r & ~link.scl;
  assign link.sda_oe_s = sda_oe_r;
  assign tx_take = (st_r == S_MACK) & rise_c & ~link.sda;

  function automatic logic addr_match(input logic [7:0] b);
    return b[CODE_MSB:CODE_LSB] == CTRL_CODE && b[SEL_MSB:SEL_LSB] == SELECT_BITS;
  endfunction

  // ***********************************************************
  // line sampling
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= link.scl;
      sda_d_r <= link.sda;
    end
  end

  // ***********************************************************
  // protocol engine
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= S_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
      rd_mode_r <= 1'b0;
      addressed_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (start_c) begin
        st_r <= S_ADDR;
        cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        addressed_r <= 1'b0;
      end else if (stop_c) begin
        st_r <= S_IDLE;
        sda_oe_r <= 1'b0;
        addressed_r <= 1'b0;
      end else begin
        case (st_r)
          S_ADDR, S_RX: begin
            if (rise_c) begin
              sh_r <= {sh_r[6:0], link.sda};
              cnt_r <= cnt_r + 4'h1;
            end
            if (fall_c && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (st_r == S_ADDR) begin
                if (addr_match(sh_r)) begin
                  sda_oe_r <= 1'b1;
                  rd_mode_r <= sh_r[DIR_BIT];
                  addressed_r <= 1'b1;
                  st_r <= S_AACK;
                end else begin
                  st_r <= S_IDLE;
                end
              end else begin
                sda_oe_r <= 1'b1;
                rx_data_r <= sh_r;
                rx_valid_r <= 1'b1;
                st_r <= S_RACK;
              end
            end
          end
          S_AACK, S_RACK: begin
            if (fall_c) begin
              if (rd_mode_r) begin
                sh_r <= {tx_data[6:0], 1'b0};
                sda_oe_r <= ~tx_data[7];
                cnt_r <= 4'h1;
                st_r <= S_TX;
              end else begin
                sda_oe_r <= 1'b0;
                st_r <= S_RX;
              end
            end
          end
          S_TX: begin
            if (fall_c) begin
              if (cnt_r == 4'h8) begin
                sda_oe_r <= 1'b0;
                st_r <= S_MACK;
              end else begin
                sda_oe_r <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (rise_c) begin
              st_r <= link.sda ? S_IDLE : S_RACK;
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  // ***********************************************************
  // event store and lockout
  // ***********************************************************
  logic [31:0] store_cnt_r, lock_cnt_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      store_cnt_r <= 32'h0;
      lock_cnt_r <= 32'h0;
      store_done_r <= 1'b0;
      lockout_r <= 1'b0;
    end else begin
      store_done_r <= 1'b0;
      if (event_end) begin
        store_cnt_r <= 32'(STORE_N);
        lock_cnt_r <= 32'(LOCKOUT_N);
        lockout_r <= 1'b1;
      end else begin
        if (store_cnt_r != 32'h0) begin
          store_cnt_r <= store_cnt_r - 32'h1;
          store_done_r <= (store_cnt_r == 32'h1);
        end
        if (lock_cnt_r != 32'h0) begin
          lock_cnt_r <= lock_cnt_r - 32'h1;
        end else begin
          lockout_r <= 1'b0;
        end
      end
    end
  end

  // ***********************************************************
  // alarm flash; own drive excluded from trigger sense
  // ***********************************************************
  logic [31:0] fl_cnt_r, low_cnt_r;
  logic [2:0]  fl_num_r;
  logic        ext_low_c, trig_r;
  assign ext_low_c = ~alarm_in & ~alarm_oe_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_r <= 32'h0;
      trig_r <= 1'b0;
    end else begin
      trig_r <= 1'b0;
      if (ext_low_c) begin
        low_cnt_r <= low_cnt_r + 32'h1;
      end else begin
        low_cnt_r <= 32'h0;
        trig_r <= (low_cnt_r >= 32'(TRIG_N)) && flash_mode;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fl_cnt_r <= 32'h0;
      fl_num_r <= 3'h0;
      alarm_oe_r <= 1'b0;
    end else if (trig_r && fl_num_r == 3'h0) begin
      fl_num_r <= 3'(FLASH_COUNT);
      alarm_oe_r <= 1'b1;
      fl_cnt_r <= 32'(FL_LOW_N);
    end else if (fl_num_r != 3'h0) begin
      if (fl_cnt_r > 32'h1) begin
        fl_cnt_r <= fl_cnt_r - 32'h1;
      end else if (alarm_oe_r) begin
        alarm_oe_r <= 1'b0;
        fl_cnt_r <= 32'(FL_HIGH_N);
      end else begin
        fl_num_r <= fl_num_r - 3'h1;
        alarm_oe_r <= (fl_num_r != 3'h1);
        fl_cnt_r <= 32'(FL_LOW_N);
      end
    end
  end
endmodule

// file: etr_master.sv
/*
  Master end: issues start, address, write or read bytes, repeated start
  and stop. Assumes one slave and a 10 MHz core clock.
*/
`timescale 1ns/1ps
module etr_master
  import etr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  etr_link_if.master      link,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_last,
  output logic            cmd_ready,
  output logic [7:0]      rd_data_r,
  output logic            done_r,
  output logic            nack_r
);
  // ops: 0 start+byte, 1 write byte, 2 read byte, 3 stop
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mst_e;
  mst_e       st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [1:0] ph_r;
  logic [7:0] tm_r;
  logic       rd_r, last_r, scl_oe_r, sda_oe_r;
  logic       tick_c;

  assign tick_c = (tm_r == 8'(SCL_HALF_CYC / 2 - 1));
  assign cmd_ready = (st_r == M_IDLE);
  assign link.scl_oe_m = scl_oe_r;
  assign link.sda_oe_m = sda_oe_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tm_r <= 8'h00;
    end else begin
      tm_r <= (tick_c || st_r == M_IDLE) ? 8'h00 : tm_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= M_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      ph_r <= 2'h0;
      rd_r <= 1'b0;
      last_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rd_data_r <= 8'h00;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        M_IDLE: begin
          if (cmd_valid) begin
            sh_r <= cmd_data;
            rd_r <= (cmd_op == 2'h2);
            last_r <= cmd_last;
            bit_r <= 4'h0;
            ph_r <= 2'h0;
            st_r <= (cmd_op == 2'h0) ? M_START : (cmd_op == 2'h3) ? M_STOP : M_BIT;
          end
        end
        M_START: if (tick_c) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b1;
            default: begin
              scl_oe_r <= 1'b1;
              st_r <= M_BIT;
            end
          endcase
        end
        M_BIT, M_ACK: if (tick_c) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: begin
              if (st_r == M_BIT) begin
                sda_oe_r <= rd_r ? 1'b0 : ~sh_r[7];
              end else begin
                sda_oe_r <= rd_r & ~last_r;
              end
            end
            2'h1: scl_oe_r <= 1'b0;
            2'h2: begin
              if (st_r == M_BIT) begin
                sh_r <= {sh_r[6:0], link.sda};
              end else if (!rd_r) begin
                nack_r <= link.sda;
              end
            end
            default: begin
              scl_oe_r <= 1'b1;
              if (st_r == M_ACK) begin
                sda_oe_r <= 1'b0;
                rd_data_r <= sh_r;
                done_r <= 1'b1;
                st_r <= M_IDLE;
              end else if (bit_r == 4'h7) begin
                st_r <= M_ACK;
              end else begin
                bit_r <= bit_r + 4'h1;
              end
            end
          endcase
        end
        // stop: sda rises with scl high
        M_STOP: if (tick_c) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            default: begin
              done_r <= 1'b1;
              st_r <= M_IDLE;
            end
          endcase
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end
endmodule

// file: etr_link_properties.sv
/*
  Wire checks for the recorder two-wire link.
  Assumes the lines change well apart from sys_clk edges.
*/
`timescale 1ns/1ps
module etr_link_properties
  import etr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_d, sda_d, first_r, match_r, rd_r, on_r;
  logic [3:0] bits_r;
  logic [6:0] sh_r;
  // ****************
  // bus decode
  // ****************
  wire st   = scl & scl_d & sda_d & ~sda;
  wire sp   = scl & scl_d & ~sda_d & sda;
  wire rise = scl & ~scl_d;
  // line history, idle high
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) {scl_d, sda_d} <= 2'h3;
    else {scl_d, sda_d} <= {scl, sda};
  // bit slots; the ninth is the ack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bits_r <= 4'h0;
      first_r <= 1'b0;
      on_r <= 1'b0;
    end else if (st) begin
      bits_r <= 4'h0;
      first_r <= 1'b1;
      on_r <= 1'b1;
    end else if (sp) begin
      first_r <= 1'b0;
      on_r <= 1'b0;
    end else if (rise && bits_r == 4'h8) begin
      bits_r <= 4'h0;
      first_r <= 1'b0;
    end else if (rise) bits_r <= bits_r + 4'h1;
  end
  // address byte capture
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= 7'h00;
      match_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (st) match_r <= 1'b0;
    else if (rise && bits_r < 4'h8) begin
      sh_r <= {sh_r[5:0], sda};
      if (first_r && bits_r == 4'h7) begin
        match_r <= sh_r == {CTRL_CODE, SELECT_BITS};
        rd_r <= sda;
      end
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_ack; rise && bits_r == 4'h8; endsequence
  sequence s_off2; !sda_oe_s [*2]; endsequence
  property p_addr_quiet; first_r && bits_r < 4'h8 |-> !sda_oe_s; endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove address");
  property p_ack_match; s_ack ##0 (first_r && match_r) |-> sda_oe_s; endproperty
  a_ack_match: assert property (p_ack_match) else $error("no ack on match");
  property p_nack_miss; s_ack ##0 (first_r && !match_r) |-> !sda_oe_s; endproperty
  a_nack_miss: assert property (p_nack_miss) else $error("ack on mismatch");
  property p_silent; on_r && !first_r && !match_r |-> !sda_oe_s; endproperty
  a_silent: assert property (p_silent) else $error("drove after mismatch");
  property p_wr_ack; s_ack ##0 (!first_r && match_r && !rd_r) |-> sda_oe_s; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("data byte not acked");
  property p_rd_free; s_ack ##0 (!first_r && match_r && rd_r) |-> !sda_oe_s; endproperty
  a_rd_free: assert property (p_rd_free) else $error("ack slot not freed");
  property p_hold_high; scl && scl_d |-> $stable(sda_oe_s); endproperty
  a_hold_high: assert property (p_hold_high) else $error("sda moved, scl high");
  property p_stop_rel; sp |=> s_off2; endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("sda held after stop");
endmodule

// file: elapsed_time_recorder_twowire_slave_test.sv
/*
  Self-checking bench: master end facing slave end over the link.
  Assumes etr_pkg, etr_link_if and both ends compiled first.
*/
`timescale 1ns/1ps
module elapsed_time_recorder_twowire_slave_test
  import etr_pkg::*;
;
  localparam int N = 20;
  logic sys_clk = 0, rstn = 0, cv = 0, cl = 0, ev = 0, fm = 0, pull = 0;
  logic [1:0] op = 0;
  logic [7:0] cd = 0, txd = 0, rd, rx, b;
  logic cr, dn, nk, tk, rv, rm, ad, aoe, sd, lk;
  int failures = 0, n_checks = 0, i, k, lc, si, lo, np;
  int unsigned seed = 82878;
  logic [7:0] exp_q[$], wq[$];
  logic [7:0] bad[5] = '{8'h56, 8'hD0, 8'hD2, 8'hDE, 8'hF6};
  etr_link_if link();
  etr_master etr_master_inst(.sys_clk, .rstn, .link(link), .cmd_valid(cv), .cmd_op(op),
    .cmd_data(cd), .cmd_last(cl), .cmd_ready(cr), .rd_data_r(rd), .done_r(dn), .nack_r(nk));
  etr_slave #(.LOCKOUT_N(N), .STORE_N(N), .FL_LOW_N(N), .FL_HIGH_N(N), .TRIG_N(N))
    etr_slave_inst(.sys_clk, .rstn, .link(link), .tx_data(txd), .tx_take(tk), .rx_data_r(rx),
    .rx_valid_r(rv), .rd_mode_r(rm), .addressed_r(ad), .event_end(ev), .flash_mode(fm),
    .alarm_in(~aoe & ~pull), .alarm_oe_r(aoe), .store_done_r(sd), .lockout_r(lk));
  etr_link_properties etr_link_properties_inst(.sys_clk, .rstn, .scl_oe_m(link.scl_oe_m),
    .sda_oe_m(link.sda_oe_m), .sda_oe_s(link.sda_oe_s), .scl(link.scl), .sda(link.sda));
  initial forever #50 sys_clk = ~sys_clk;
  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hold request until taken, then wait for done
  task automatic cmd(input logic [1:0] o, input logic [7:0] d, input logic l);
    cv = 1;
    op = o;
    cd = d;
    cl = l;
    for (i = 0; !cr && i < 3000; i++) @(posedge sys_clk) #5;
    if (i >= 3000) begin
      failures++;
      report_and_stop();
    end
    @(posedge sys_clk) #5;
    cv = 0;
    for (i = 0; !dn && i < 5000; i++) @(posedge sys_clk) #5;
    if (i >= 5000) begin
      failures++;
      report_and_stop();
    end
  endtask
  // written bytes against the model queue; empty queue means none due
  always @(negedge sys_clk) if (rv === 1'b1) begin
    if (wq.size() == 0) chk(rv, 0, "stray rx");
    else chk(rx, wq.pop_front(), "rx byte");
  end
  // a take means the slave loads tx_data at the next scl fall,
  // so a fresh byte goes on offer now and is the one expected next
  always @(negedge sys_clk) if (tk === 1'b1) begin
    @(posedge sys_clk) #5 txd = rnd();
    exp_q.push_back(txd);
  end
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (2) @(posedge sys_clk);
    #5 rstn = 1;
    txd = rnd();
    cmd(0, 8'hD6, 0);
    chk(nk, 0, "addr ack");
    chk({ad, rm}, 8'h2, "write mode");
    repeat (3) begin
      b = rnd();
      wq.push_back(b);
      cmd(1, b, 0);
      chk(nk, 0, "data ack");
    end
    exp_q.push_back(txd);
    cmd(0, 8'hD7, 0);
    chk({nk, rm}, 8'h1, "read mode");
    for (k = 0; k < 3; k++) begin
      cmd(2, 0, k == 2);
      chk(rd, exp_q.pop_front(), "rd byte");
    end
    cmd(3, 0, 0);
    chk(ad, 0, "stop ends");
    // wrong code or select bits, then a write that must be ignored
    foreach (bad[j]) begin
      cmd(0, bad[j], 0);
      chk({nk, ad}, 8'h2, "mismatch");
      cmd(1, rnd(), 0);
      chk(nk, 1, "ignored");
      cmd(3, 0, 0);
    end
    ev = 1;
    @(posedge sys_clk) #5 ev = 0;
    for (k = 0, lc = 0, si = -1; k < 3 * N + 10; k++) begin
      @(negedge sys_clk);
      lc += lk;
      if (sd) si = k;
    end
    chk(8'(lc), 8'(N + 1), "lockout len");
    chk(si inside {[N - 1:N + 2]}, 1, "store time");
    // long pull with flash mode off must not flash
    @(posedge sys_clk) #5 pull = 1;
    repeat (N + 2) @(posedge sys_clk);
    #5 pull = 0;
    for (k = 0, lo = 0; k < 3 * N; k++) begin
      @(negedge sys_clk);
      lo += aoe;
    end
    chk(8'(lo), 8'h00, "flash mode off");
    @(posedge sys_clk) #5 fm = 1;
    pull = 1;
    repeat (N + 2) @(posedge sys_clk);
    #5 pull = 0;
    for (k = 0, lo = 0, np = 0, b = 0; k < 8 * N + 40; k++) begin
      @(negedge sys_clk);
      lo += aoe;
      np += (aoe && !b[0]);
      b[0] = aoe;
    end
    chk(8'(np), 8'(FLASH_COUNT), "flashes");
    chk(8'(lo), 8'(FLASH_COUNT * N), "low time");
    report_and_stop();
  end
endmodule
